//--- inc/sla_defines.svh
// constants of the sct log access decoder: opcodes, pages, layout
// assumes inclusion by bare name from the package and the design files
`ifndef SLA_DEFINES_SVH
`define SLA_DEFINES_SVH

// ****************************************
// command and taskfile values
// ****************************************
`define SLA_OP_SMART 8'hb0
`define SLA_OP_LOG_RD 8'h2f
`define SLA_OP_LOG_WR 8'h3f
`define SLA_FEAT_RD 8'hd5
`define SLA_FEAT_WR 8'hd6
`define SLA_SIG_LO 8'h4f
`define SLA_SIG_HI 8'hc2
`define SLA_PAGE_STAT 8'he0
`define SLA_PAGE_DATA 8'he1
`define SLA_ZERO_BYTE 8'h00
`define SLA_ONE_SECT 8'h01

// ****************************************
// status page layout, 16-bit word indexes
// ****************************************
`define SLA_LAST_WORD 8'hff
`define SLA_W_FORMAT 8'h00
`define SLA_W_VERSION 8'h01
`define SLA_W_SPEC 8'h02
`define SLA_W_FLAGS 8'h03
`define SLA_W_DRIVE 8'h05
`define SLA_W_EXT 8'h07
`define SLA_W_ACTION 8'h08
`define SLA_W_FUNC 8'h09
`define SLA_W_LBA0 8'h14
`define SLA_W_LBA1 8'h15
`define SLA_W_LBA2 8'h16
`define SLA_W_TEMP 8'h64
`define SLA_W_TMAX 8'h65
`define SLA_FORMAT_VER 16'h0003
`define SLA_SPEC_LEVEL 16'h0001
`define SLA_EXT_BUSY 16'hffff
`define SLA_DRV_SCT_BG 8'h05
`define SLA_ZERO_WORD 16'h0000

`endif

//--- inc/sla_pkg.sv
// types of the sct log access decoder
// assumes sla_defines.svh on the include path
package sla_pkg;
  `include "sla_defines.svh"

  typedef logic [7:0] sla_byte_t;
  typedef logic [15:0] sla_word_t;

  // one-hot decoder states
  typedef enum logic [3:0] {
    SLA_IDLE = 4'h1,
    SLA_STAT = 4'h2,
    SLA_FIN = 4'h4,
    SLA_XFER = 4'h8
  } sla_state_e;
endpackage

//--- inc/sla_stat_if.sv
// carrier between the decoder and its status page memory
// assumes one clock shared by both ends
interface sla_stat_if;
  logic [7:0] rd_addr;
  logic [15:0] rd_data;
  logic bg_busy;
  logic [15:0] ext_status;
  logic [15:0] action_code;
  logic [15:0] func_code;
  logic [7:0] drive_state;
  logic seg_init;
  logic [47:0] cur_lba;
  logic [7:0] hda_temp;
  logic [7:0] min_temp;
  logic [7:0] max_temp;

  modport dec (output rd_addr, bg_busy, ext_status, action_code, func_code,
    drive_state, seg_init, cur_lba, hda_temp, min_temp, max_temp,
    input rd_data);
  modport mem (input rd_addr, bg_busy, ext_status, action_code, func_code,
    drive_state, seg_init, cur_lba, hda_temp, min_temp, max_temp,
    output rd_data);
endinterface

//--- hdl/sla_status_mem.sv
// status page store: one 512-byte page as 256 words, registered read
// assumes the decoder steps rd_addr one word per clock

`include "sla_defines.svh"

module sla_status_mem
  import sla_pkg::*;
#(
  parameter logic [15:0] SCT_VERSION = 16'h0001 // arbitrary value
) (
  input wire logic clk,
  input wire logic srst,
  sla_stat_if.mem st
);
  // ****************************************
  // word selection
  // ****************************************
  sla_word_t word_next;
  sla_word_t ext_word;
  sla_word_t drive_word;

  // background run forces the busy code and state
  assign ext_word = st.bg_busy ? `SLA_EXT_BUSY : st.ext_status; // R13
  assign drive_word = {`SLA_ZERO_BYTE,
    st.bg_busy ? `SLA_DRV_SCT_BG : st.drive_state};

  always_comb begin
    case (st.rd_addr)
      `SLA_W_FORMAT: word_next = `SLA_FORMAT_VER;
      `SLA_W_VERSION: word_next = SCT_VERSION;
      `SLA_W_SPEC: word_next = `SLA_SPEC_LEVEL;
      `SLA_W_FLAGS: word_next = {15'h0000, st.seg_init};
      `SLA_W_DRIVE: word_next = drive_word;
      `SLA_W_EXT: word_next = ext_word; // R6
      `SLA_W_ACTION: word_next = st.action_code;
      `SLA_W_FUNC: word_next = st.func_code;
      `SLA_W_LBA0: word_next = st.cur_lba[15:0];
      `SLA_W_LBA1: word_next = st.cur_lba[31:16];
      `SLA_W_LBA2: word_next = st.cur_lba[47:32];
      `SLA_W_TEMP: word_next = {st.min_temp, st.hda_temp};
      `SLA_W_TMAX: word_next = {`SLA_ZERO_BYTE, st.max_temp};
      default: word_next = `SLA_ZERO_WORD;
    endcase
  end

  // registered read port
  always_ff @(posedge clk) begin
    if (srst) begin
      st.rd_data <= `SLA_ZERO_WORD;
    end else begin
      st.rd_data <= word_next;
    end
  end

  a_busy_ext_code: assert property (@(posedge clk) disable iff (srst) // R13
    (st.rd_addr == `SLA_W_EXT && st.bg_busy) |=>
      st.rd_data == `SLA_EXT_BUSY)
    else $error("busy extended status not reported");
endmodule

//--- hdl/sla_decoder.sv
// sct log access decoder: smart and extended log paths to the sct pages
// assumes taskfile bytes stable while cmd_valid is high, one clock domain
//
// Contract
// [R1] smart opcode, sector number e1h, cylinder high c2h means sct data
// [R2] smart data moves exactly the sector count given
// [R3] extended log read or write with address byte e1h is sct data
// [R4] host zeroes upper count and both middle address bytes
// [R5] command status only tells accepted or rejected, not action done
// [R6] status page e0h is returned whenever the host reads it
// [R7] status request accepted any time, even during background sct work
// [R8] status request leaves power state and background work untouched
// [R9] smart status: one sector, number e0h, cylinder low 4fh
// [R10] extended status: log read, address e0h, upper bytes zero
// [R11] host polls status repeatedly to follow long actions
// [R12] after an accepted sct command, data goes through page e1h
// [R13] extended status reads ffffh while sct runs in background
// [R14] log access to any other page is aborted with error

`include "sla_defines.svh"

module sla_decoder
  import sla_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_feature,
  input wire logic [7:0] cmd_count,
  input wire logic [7:0] cmd_count_prev,
  input wire logic [7:0] cmd_lba_low,
  input wire logic [7:0] cmd_lba_mid,
  input wire logic [7:0] cmd_lba_mid_prev,
  input wire logic [7:0] cmd_lba_high,
  input wire logic sector_done,
  input wire logic bg_busy,
  input wire logic [15:0] bg_ext_status,
  input wire logic [15:0] bg_action,
  input wire logic [15:0] bg_function,
  input wire logic [7:0] drive_state,
  input wire logic seg_init,
  input wire logic [47:0] bg_lba,
  input wire logic [7:0] hda_temp,
  input wire logic [7:0] min_temp,
  input wire logic [7:0] max_temp,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_err,
  output logic [15:0] stat_word,
  output logic stat_word_valid,
  output logic xfer_active,
  output logic xfer_write,
  output logic [7:0] xfer_sectors
);
  // ****************************************
  // status page memory
  // ****************************************
  sla_stat_if st ();
  sla_state_e state_reg;
  sla_state_e state_next;
  sla_byte_t addr_reg;
  sla_byte_t remain_reg;
  logic issue_reg;
  logic done_reg;
  logic err_reg;
  logic word_valid_reg;
  sla_word_t word_reg;
  logic xact_reg;
  logic xwr_reg;
  sla_byte_t xcnt_reg;

  // snapshot fields fed straight to the page, read-only view
  assign st.rd_addr = addr_reg;
  assign st.bg_busy = bg_busy; // R8
  assign st.ext_status = bg_ext_status;
  assign st.action_code = bg_action;
  assign st.func_code = bg_function;
  assign st.drive_state = drive_state;
  assign st.seg_init = seg_init;
  assign st.cur_lba = bg_lba;
  assign st.hda_temp = hda_temp;
  assign st.min_temp = min_temp;
  assign st.max_temp = max_temp;

  sla_status_mem u_mem (
    .clk(clk),
    .srst(srst),
    .st(st.mem)
  );

  // ****************************************
  // taskfile decode
  // ****************************************
  function automatic logic is_zero(input sla_byte_t b);
    is_zero = (b == `SLA_ZERO_BYTE);
  endfunction

  logic idle;
  logic take;
  logic smart_sig;
  logic smart_data;
  logic smart_stat;
  logic ext_zero;
  logic ext_rd;
  logic ext_wr;
  logic ext_data;
  logic ext_stat;
  logic want_data;
  logic want_stat;
  logic want_write;
  logic bad_cmd;
  logic last_sector;

  // smart path signature bytes
  assign smart_sig = cmd_op == `SLA_OP_SMART && cmd_lba_mid == `SLA_SIG_LO
    && cmd_lba_high == `SLA_SIG_HI;
  assign smart_data = smart_sig && cmd_lba_low == `SLA_PAGE_DATA // R1
    && (cmd_feature == `SLA_FEAT_RD || cmd_feature == `SLA_FEAT_WR)
    && !is_zero(cmd_count);
  assign smart_stat = smart_sig && cmd_lba_low == `SLA_PAGE_STAT // R9
    && cmd_feature == `SLA_FEAT_RD && cmd_count == `SLA_ONE_SECT;
  // extended log path, upper bytes must be zero
  assign ext_zero = is_zero(cmd_count_prev) && is_zero(cmd_lba_mid) // R4
    && is_zero(cmd_lba_mid_prev);
  assign ext_rd = cmd_op == `SLA_OP_LOG_RD;
  assign ext_wr = cmd_op == `SLA_OP_LOG_WR;
  assign ext_data = (ext_rd || ext_wr) && cmd_lba_low == `SLA_PAGE_DATA // R3
    && ext_zero && !is_zero(cmd_count);
  assign ext_stat = ext_rd && cmd_lba_low == `SLA_PAGE_STAT // R10
    && ext_zero && cmd_count == `SLA_ONE_SECT;
  // classification of a taken command
  assign idle = state_reg == SLA_IDLE;
  assign take = idle && cmd_valid;
  assign want_data = smart_data || ext_data; // R12
  assign want_stat = smart_stat || ext_stat; // R7
  assign want_write = smart_data ? (cmd_feature == `SLA_FEAT_WR) : ext_wr;
  assign bad_cmd = !want_data && !want_stat; // R14
  assign last_sector = sector_done && remain_reg == `SLA_ONE_SECT; // R2

  // ****************************************
  // control state machine
  // ****************************************
  always_comb begin
    case (state_reg)
      SLA_IDLE: begin
        if (take && want_stat) begin
          state_next = SLA_STAT; // R7
        end else if (take && want_data) begin
          state_next = SLA_XFER;
        end else begin
          state_next = SLA_IDLE;
        end
      end
      SLA_STAT: begin
        state_next = (addr_reg == `SLA_LAST_WORD) ? SLA_FIN : SLA_STAT;
      end
      SLA_FIN: state_next = SLA_IDLE;
      SLA_XFER: state_next = last_sector ? SLA_IDLE : SLA_XFER; // R2
      default: state_next = SLA_IDLE;
    endcase
  end

  // state and page address
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SLA_IDLE;
      addr_reg <= `SLA_ZERO_BYTE;
      issue_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= (state_reg == SLA_STAT) ? addr_reg + 8'h01 : 8'h00; // R6
      issue_reg <= state_reg == SLA_STAT;
    end
  end

  // status words out, one per clock
  always_ff @(posedge clk) begin
    if (srst) begin
      word_reg <= `SLA_ZERO_WORD;
      word_valid_reg <= 1'b0;
    end else begin
      word_reg <= issue_reg ? st.rd_data : `SLA_ZERO_WORD;
      word_valid_reg <= issue_reg; // R6
    end
  end

  // completion only says accepted or aborted
  always_ff @(posedge clk) begin
    if (srst) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      done_reg <= (take && bad_cmd) || state_reg == SLA_FIN // R5
        || (state_reg == SLA_XFER && last_sector);
      err_reg <= take && bad_cmd; // R14
    end
  end

  // data transfer through the data page
  always_ff @(posedge clk) begin
    if (srst) begin
      xact_reg <= 1'b0;
      xwr_reg <= 1'b0;
      xcnt_reg <= `SLA_ZERO_BYTE;
      remain_reg <= `SLA_ZERO_BYTE;
    end else if (take && want_data) begin
      xact_reg <= 1'b1; // R12
      xwr_reg <= want_write;
      xcnt_reg <= cmd_count; // R2
      remain_reg <= cmd_count;
    end else if (xact_reg && sector_done) begin
      xact_reg <= !last_sector;
      remain_reg <= remain_reg - 8'h01;
    end
  end

  assign cmd_done = done_reg;
  assign cmd_err = err_reg;
  assign stat_word = word_reg;
  assign stat_word_valid = word_valid_reg;
  assign xfer_active = xact_reg;
  assign xfer_write = xwr_reg;
  assign xfer_sectors = xcnt_reg;

  // ready is registered from the next state
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_ready <= 1'b1;
    end else begin
      cmd_ready <= state_next == SLA_IDLE;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [8:0] wcnt_reg;
  always_ff @(posedge clk) begin
    if (srst || take) begin
      wcnt_reg <= 9'h000;
    end else if (word_valid_reg) begin
      wcnt_reg <= wcnt_reg + 9'h001;
    end
  end

  a_bad_page_abort: assert property (@(posedge clk) disable iff (srst) // R14
    (take && bad_cmd) |=> (cmd_done && cmd_err && !xfer_active))
    else $error("unknown page not aborted");
  a_status_completes: assert property (@(posedge clk) disable iff (srst) // R6
    (take && want_stat) |-> ##258 (cmd_done && !cmd_err && stat_word_valid))
    else $error("status read did not finish on time");
  a_status_word_count: assert property (@(posedge clk) disable iff (srst) // R6
    (cmd_done && !cmd_err && !$past(xact_reg)) |-> wcnt_reg == 9'h0ff)
    else $error("status page not full length");
  a_status_while_busy: assert property (@(posedge clk) disable iff (srst) // R7
    (take && want_stat && bg_busy) |=> state_reg == SLA_STAT)
    else $error("status refused during background work");
  a_xfer_start: assert property (@(posedge clk) disable iff (srst) // R1
    (take && want_data) |=> (xfer_active && xfer_sectors == $past(cmd_count)))
    else $error("data transfer not started");
  a_xfer_exact: assert property (@(posedge clk) disable iff (srst) // R2
    (xfer_active && last_sector) |=> (cmd_done && !cmd_err && !xfer_active))
    else $error("transfer did not end on last sector");
  a_done_single: assert property (@(posedge clk) disable iff (srst) // R5
    (cmd_done && !take) |=> !cmd_done)
    else $error("completion longer than one cycle");
  a_ext_upper_zero: assert property (@(posedge clk) disable iff (srst) // R4
    (take && (ext_rd || ext_wr) && !is_zero(cmd_lba_mid)) |=> cmd_err)
    else $error("nonzero middle address accepted");
  a_ext_status_path: assert property (@(posedge clk) disable iff (srst) // R10
    (take && ext_rd && cmd_lba_low == `SLA_PAGE_STAT && ext_zero
      && cmd_count == `SLA_ONE_SECT) |=> ##2 stat_word_valid)
    else $error("extended status request not served");
endmodule

//--- test/sla_host_model.sv
// far side of the data path: pulses sector_done while a transfer runs
// assumes xfer_active from the decoder and one shared clock
module sla_host_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic xfer_active,
  output logic sector_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed;
  logic [31:0] r;

  initial begin
    seed = 25;
    sector_done = 1'b0;
  end

  // ****************************************
  // sector pacing
  // ****************************************
  // one pulse per sector, always an idle cycle after a pulse
  always @(posedge clk) begin
    r = $random(seed);
    if (srst || sector_done || !xfer_active) begin
      sector_done <= #1 1'b0;
    end else begin
      sector_done <= #1 (stall ? r[2:0] == 3'h0 : r[0]); // slow or prompt
    end
  end
endmodule

//--- test/testbench.sv
// self-checking bench of the sct log access decoder
// assumes sla_pkg compiled first and sla_host_model on the far side
module testbench
  import sla_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, cmd_valid, sector_done, bg_busy, seg_init, stall;
  logic [7:0] op, feat, cnt, cntp, lo, mid, midp, hi;
  logic [15:0] bext, bact, bfun, stat_word;
  logic [7:0] dst, tc, tmin, tmax, xfer_sectors;
  logic [47:0] blba;
  logic cmd_ready, cmd_done, cmd_err, stat_word_valid;
  logic xfer_active, xfer_write;
  logic [31:0] r;
  logic [63:0] tbl [14];
  logic [15:0] words [$];
  int bad_count, comparisons, seed, i, moved;

  sla_decoder i_sla_decoder (.clk(clk), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_op(op), .cmd_feature(feat),
    .cmd_count(cnt), .cmd_count_prev(cntp), .cmd_lba_low(lo),
    .cmd_lba_mid(mid), .cmd_lba_mid_prev(midp), .cmd_lba_high(hi),
    .sector_done(sector_done), .bg_busy(bg_busy),
    .bg_ext_status(bext), .bg_action(bact), .bg_function(bfun),
    .drive_state(dst), .seg_init(seg_init), .bg_lba(blba),
    .hda_temp(tc), .min_temp(tmin), .max_temp(tmax),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_err(cmd_err),
    .stat_word(stat_word), .stat_word_valid(stat_word_valid),
    .xfer_active(xfer_active), .xfer_write(xfer_write),
    .xfer_sectors(xfer_sectors));

  sla_host_model i_sla_host_model (.clk(clk), .srst(srst),
    .stall(stall), .xfer_active(xfer_active),
    .sector_done(sector_done));

  // ****************************************
  // reference model and helpers
  // ****************************************
  // 0 abort, 1 status page, 2 data transfer
  function automatic int kind();
    int sm, ex;
    sm = op == 8'hb0 && mid == 8'h4f && hi == 8'hc2;
    ex = (op == 8'h2f || op == 8'h3f) && cntp == 0 && mid == 0 && midp == 0;
    if (sm && lo == 8'he1 && (feat == 8'hd5 || feat == 8'hd6) && cnt != 0)
      return 2;
    if (sm && lo == 8'he0 && feat == 8'hd5 && cnt == 1)
      return 1;
    if (ex && lo == 8'he1 && cnt != 0)
      return 2;
    if (ex && lo == 8'he0 && op == 8'h2f && cnt == 1)
      return 1;
    return 0;
  endfunction

  // expected status page word from the page layout
  function automatic logic [15:0] page_word(input int n);
    case (n)
      0: return 16'h0003;
      1: return 16'h0001; // default implementation version
      2: return 16'h0001;
      3: return {15'h0000, seg_init};
      5: return {8'h00, bg_busy ? 8'h05 : dst};
      7: return bg_busy ? 16'hffff : bext;
      8: return bact;
      9: return bfun;
      20: return blba[15:0];
      21: return blba[31:16];
      22: return blba[47:32];
      100: return {tmin, tc};
      101: return {8'h00, tmax};
      default: return 16'h0000;
    endcase
  endfunction

  // sectors handed over while a transfer runs, as the edge sees them
  always @(posedge clk) begin
    if (xfer_active === 1'b1 && sector_done === 1'b1) moved++;
  end

  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task give_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // present the current taskfile once and judge the answer
  task automatic run();
    int k, ex;
    logic xa, xw, rd1;
    logic [7:0] xs;
    ex = kind();
    k = 0;
    moved = 0;
    rd1 = 0;
    xa = 0;
    xw = 0;
    xs = 0;
    words.delete();
    r = $random(seed);
    {bext, bact} = r;
    r = $random(seed);
    {bfun, dst, tc} = r;
    r = $random(seed);
    blba = {r[15:0], r};
    {tmin, tmax, bg_busy, seg_init} = r[17:0];
    chk("cmd_ready", 1, cmd_ready);
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    // look once just after every edge, starting with the take edge
    forever begin
      k++;
      if (stat_word_valid === 1'b1) words.push_back(stat_word);
      if (k == 1) begin
        {xa, xw, xs} = {xfer_active, xfer_write, xfer_sectors};
        rd1 = cmd_ready;
      end
      if (cmd_done === 1'b1 || k >= 3000) break;
      @(posedge clk);
      #1;
    end
    chk("cmd_done", 1, cmd_done);
    chk("cmd_err", ex == 0, cmd_err);
    chk("cmd_ready busy", ex == 0, rd1);
    chk("xfer_active", ex == 2, xa);
    chk("xfer_active end", 0, xfer_active);
    chk("word count", ex == 1 ? 256 : 0, words.size());
    if (ex == 0) chk("abort latency", 1, k);
    if (ex == 1) begin
      chk("status latency", 258, k);
      chk("word0", 16'h0003, words[0]);
      chk("word7", bg_busy ? 16'hffff : bext, words[7]);
      chk("word8", bact, words[8]);
      for (int j = 0; j < words.size(); j++)
        chk($sformatf("word%0d", j), page_word(j), words[j]);
    end
    if (ex == 2) begin
      chk("sectors moved", cnt, moved);
      chk("xfer_sectors", cnt, xs);
      chk("xfer_write", op == 8'h3f || (op == 8'hb0 && feat == 8'hd6),
        xw);
    end
  endtask

  // ****************************************
  // clock, stimulus and watchdog
  // ****************************************
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  // op feat count count_prev lba_low mid mid_prev high
  initial begin
    tbl = '{64'hb0d50300e14f00c2, 64'hb0d60100e14f00c2,
      64'hb0d50100e04f00c2, 64'h2f000800e1000000,
      64'h3f000100e1000000, 64'h2f000100e0000000,
      64'h2f000100e0000000, 64'h3f000100e0000000,
      64'h2f000100300000ff, 64'h2f000100e1010000,
      64'h2f000101e1000000, 64'hb0d50000e14f00c2,
      64'hb0d50200e04f00c2, 64'hb0d50100e14f00c3};
    seed = 25;
    bad_count = 0;
    comparisons = 0;
    srst = 1;
    cmd_valid = 0;
    stall = 0;
    {op, feat, cnt, cntp, lo, mid, midp, hi} = 64'h0;
    {bext, bact, bfun, dst, tc, tmin, tmax, blba} = 136'h0;
    {bg_busy, seg_init} = 2'h0;
    repeat (5) @(posedge clk);
    #1 srst = 0;
    for (i = 0; i < 14; i++) begin
      {op, feat, cnt, cntp, lo, mid, midp, hi} = tbl[i];
      stall = i[0];
      run();
    end
    // random commands near the legal forms
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      op = r[1:0] == 0 ? 8'hb0 : r[1:0] == 1 ? 8'h2f :
        r[1:0] == 2 ? 8'h3f : r[15:8];
      lo = r[3] ? 8'he0 : r[4] ? 8'he1 : r[23:16];
      feat = r[5] ? 8'hd5 : 8'hd6;
      cnt = {5'h0, r[26:24]};
      cntp = 8'h0;
      mid = (op == 8'hb0 ? 8'h4f : 8'h00) ^ {7'h0, r[31:29] == 0};
      midp = {7'h0, r[28:27] == 0};
      hi = op == 8'hb0 ? 8'hc2 : 8'h00;
      stall = r[6];
      run();
    end
    give_verdict();
  end

  initial begin
    // twenty times the 3000-cycle cap of a single run
    #1200000;
    bad_count++;
    give_verdict();
  end
endmodule
